// ---- thr_switch.v ----
// Purpose: Second threshold channel: hysteresis comparator with delays and sending
// Assumes: Classic Wishbone slave, one clock, synchronous reset
// Notes:   Time base ticks every 100 ms; telegram is a one-cycle pulse with value
// Function
// - Each crossing direction maps to ON, OFF or no telegram by mode.
// - Undershoot-off mode: rising above level plus hysteresis sends nothing.
// - Exceed gives nothing; undershoot level minus hysteresis gives OFF or ON.
// - Undershoot gives nothing; exceed level plus hysteresis gives OFF or ON.
// - External source off: only the fixed level is used.
// - Wide source: level comes from a two-byte bus object.
// - Narrow source: level comes from a one-byte bus object.
// - Teach mode: writing the switch object latches present measured value.
// - Download restores fixed level; external used again after new arrival.
// - Rise to one reaches output only after selectable switch-on delay.
// - While switch-on delay runs, cyclic sends keep carrying zero.
// - Fall to zero reaches output and cyclic only after switch-off delay.
// - While switch-off delay runs, cyclic sends keep carrying one.
// - Condition set to no telegram also suppresses its cyclic sends.
// - Send-on-change off: no send on output change.
// - Send-on-change off, cycle at least one: periodic sends continue.
// - Send-on-change on sends every change; both off means never send.
// - Cyclic period is setting times ten seconds; zero disables it.
//
// Our own choices: the placing of the registers and the Wishbone interface to the registers.
`include "thr_switch_consts.vh"
module thr_switch #(
    parameter TICK_CYCLES = `TICK_CYCLES
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg         send_o,
    output reg         send_val_o
);
    // ****************************
    // Register file
    // ****************************
    reg  [3:0]  mode_r;
    reg  [1:0]  src_r;
    reg         soc_r;
    reg  [6:0]  cyc_r;
    reg  [15:0] level_r;
    reg  [15:0] hyst_r;
    reg  [3:0]  on_sel_r;
    reg  [3:0]  off_sel_r;
    reg  [15:0] ext_r;
    reg         ext_ok_r;
    reg  [15:0] meas_r;
    wire        wr = cyc_i & stb_i & we_i & ~ack_o;
    wire        dl_wr = wr && adr_i == `REG_CTRL && sel_i[0] && dat_i[`CTRL_DL_BIT];
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i & stb_i & ~ack_o;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            mode_r    <= `RST_MODE;
            src_r     <= `SRC_FIXED;
            soc_r     <= 1'b1;
            cyc_r     <= `RST_CYC;
            level_r   <= `RST_LEVEL;
            hyst_r    <= `RST_HYST;
            on_sel_r  <= `RST_DELAY_SEL;
            off_sel_r <= `RST_DELAY_SEL;
            ext_r     <= 16'h0000;
            ext_ok_r  <= 1'b0;
            meas_r    <= 16'h0000;
        end else if (wr) begin
            case (adr_i)
                `REG_CTRL: begin
                    if (sel_i[0]) begin
                        mode_r <= dat_i[3:0];
                        src_r  <= dat_i[5:4];
                        soc_r  <= dat_i[`CTRL_SOC_BIT];
                        if (dat_i[`CTRL_DL_BIT])
                            ext_ok_r <= 1'b0;
                    end
                    if (sel_i[1])
                        cyc_r <= dat_i[14:8];
                end
                `REG_LEVEL: if (sel_i[0]) level_r <= dat_i[15:0];
                `REG_HYST:  if (sel_i[0]) hyst_r <= dat_i[15:0];
                `REG_DELAY: if (sel_i[0]) begin
                    on_sel_r  <= dat_i[3:0];
                    off_sel_r <= dat_i[7:4];
                end
                `REG_EXT16: if (src_r == `SRC_WIDE && sel_i[0]) begin
                    ext_r    <= dat_i[15:0];
                    ext_ok_r <= 1'b1;
                end
                `REG_EXT8: if (src_r == `SRC_NARROW && sel_i[0]) begin
                    ext_r    <= {8'h00, dat_i[7:0]};
                    ext_ok_r <= 1'b1;
                end
                `REG_TEACH: if (src_r == `SRC_TEACH && sel_i[0]) begin
                    ext_r    <= meas_r;
                    ext_ok_r <= 1'b1;
                end
                `REG_MEAS: if (sel_i[0]) meas_r <= dat_i[15:0];
                default: ;
            endcase
        end
    end
    // ****************************
    // Threshold and comparator
    // ****************************
    wire [15:0] lvl = (src_r != `SRC_FIXED && ext_ok_r) ? ext_r : level_r;
    // Modes 0,1,4,5,8,9 and C-F: exceed level / undershoot level-hyst; modes 2,3,6,7,A,B mirrored
    reg  [1:0]  act_hi;
    reg  [1:0]  act_lo;
    reg         up_at_lvl;
    always @* begin
        act_hi    = `ACT_NONE;
        act_lo    = `ACT_NONE;
        up_at_lvl = 1'b1;
        case (mode_r)
            4'h0: begin act_hi = `ACT_ON;  act_lo = `ACT_OFF; end
            4'h1: begin act_hi = `ACT_OFF; act_lo = `ACT_ON;  end
            4'h2: begin act_lo = `ACT_ON;  act_hi = `ACT_OFF; up_at_lvl = 1'b0; end
            4'h3: begin act_lo = `ACT_OFF; act_hi = `ACT_ON;  up_at_lvl = 1'b0; end
            4'h4: act_hi = `ACT_ON;
            4'h5: act_hi = `ACT_OFF;
            4'h6: begin act_lo = `ACT_ON;  up_at_lvl = 1'b0; end
            4'h7: begin act_lo = `ACT_OFF; up_at_lvl = 1'b0; end
            4'h8: act_lo = `ACT_OFF;
            4'h9: act_lo = `ACT_ON;
            4'hA: begin act_hi = `ACT_OFF; up_at_lvl = 1'b0; end
            4'hB: begin act_hi = `ACT_ON;  up_at_lvl = 1'b0; end
            default: begin act_hi = `ACT_ON; act_lo = `ACT_OFF; end
        endcase
    end
    wire [16:0] up_pt = up_at_lvl ? {1'b0, lvl} : {1'b0, lvl} + {1'b0, hyst_r};
    wire [16:0] lo_pt = up_at_lvl ? ({1'b0, lvl} - {1'b0, hyst_r}) : {1'b0, lvl};
    wire        lo_neg = up_at_lvl && hyst_r > lvl;
    wire        above = {1'b0, meas_r} > up_pt;
    wire        below = !lo_neg && {1'b0, meas_r} < lo_pt;
    reg         hi_r;
    always @(posedge clk_i) begin
        if (rst_i)
            hi_r <= 1'b0;
        else if (above)
            hi_r <= 1'b1;
        else if (below)
            hi_r <= 1'b0;
    end
    wire [1:0] act_now  = hi_r ? act_hi : act_lo;
    wire       cond_val = (act_now == `ACT_ON);
    wire       cond_tx  = (act_now != `ACT_NONE);
    // ****************************
    // Time base
    // ****************************
    reg  [31:0] pre_r;
    wire        tick = (pre_r == TICK_CYCLES - 1);
    always @(posedge clk_i) begin
        if (rst_i || dl_wr || tick)
            pre_r <= 32'h0;
        else
            pre_r <= pre_r + 32'h1;
    end
    function [15:0] dly_ticks;
        input [3:0] s;
        begin
            case (s)
                4'h0: dly_ticks = 16'd0;
                4'h1: dly_ticks = 16'd10;
                4'h2: dly_ticks = 16'd30;
                4'h3: dly_ticks = 16'd50;
                4'h4: dly_ticks = 16'd100;
                4'h5: dly_ticks = 16'd150;
                4'h6: dly_ticks = 16'd300;
                4'h7: dly_ticks = 16'd600;
                4'h8: dly_ticks = 16'd1800;
                4'h9: dly_ticks = 16'd3000;
                4'hA: dly_ticks = 16'd6000;
                4'hB: dly_ticks = 16'd9000;
                4'hC: dly_ticks = 16'd18000;
                4'hD: dly_ticks = 16'd36000;
                default: dly_ticks = 16'd0;
            endcase
        end
    endfunction
    // ****************************
    // Delay and output object
    // ****************************
    reg         obj_r;
    reg         obj_tx_r;
    reg         pend_r;
    reg  [15:0] dcnt_r;
    wire [15:0] need = cond_val ? dly_ticks(on_sel_r) : dly_ticks(off_sel_r);
    wire        differ = cond_val != obj_r;
    wire        expire = pend_r && tick && (dcnt_r + 16'h1 >= need);
    wire        apply = differ && (need == 16'h0 || expire);
    always @(posedge clk_i) begin
        if (rst_i || dl_wr) begin
            obj_r  <= 1'b0;
            pend_r <= 1'b0;
            dcnt_r <= 16'h0;
        end else if (!differ) begin
            pend_r <= 1'b0;
            dcnt_r <= 16'h0;
        end else if (apply) begin
            obj_r  <= cond_val;
            pend_r <= 1'b0;
            dcnt_r <= 16'h0;
        end else begin
            pend_r <= 1'b1;
            if (pend_r && tick)
                dcnt_r <= dcnt_r + 16'h1;
        end
    end
    always @(posedge clk_i) begin
        if (rst_i)
            obj_tx_r <= 1'b0;
        else if (apply || !differ)
            obj_tx_r <= cond_tx;
    end
    // ****************************
    // Sending
    // ****************************
    reg  [13:0] ccnt_r;
    // Full product kept wide, then cut: 127 x 100 ticks fits in 14 bits
    wire [31:0] period_w = cyc_r * `CYC_UNIT_TICKS;
    wire [13:0] period = period_w[13:0];
    wire        cyc_hit = cyc_r != 7'h0 && tick && ccnt_r + 14'h1 >= period;
    always @(posedge clk_i) begin
        if (rst_i || dl_wr || cyc_hit)
            ccnt_r <= 14'h0;
        else if (tick && cyc_r != 7'h0)
            ccnt_r <= ccnt_r + 14'h1;
    end
    always @(posedge clk_i) begin
        if (rst_i) begin
            send_o     <= 1'b0;
            send_val_o <= 1'b0;
        end else if (apply && soc_r && cond_tx) begin
            send_o     <= 1'b1;
            send_val_o <= cond_val;
        end else if (cyc_hit && obj_tx_r) begin
            send_o     <= 1'b1;
            send_val_o <= obj_r;
        end else begin
            send_o     <= 1'b0;
        end
    end
    // ****************************
    // Read data
    // ****************************
    always @(posedge clk_i) begin
        if (rst_i)
            dat_o <= 32'h0;
        else begin
            case (adr_i)
                `REG_CTRL:   dat_o <= {17'h0, cyc_r, 1'b0, soc_r, src_r, mode_r};
                `REG_LEVEL:  dat_o <= {16'h0, level_r};
                `REG_HYST:   dat_o <= {16'h0, hyst_r};
                `REG_DELAY:  dat_o <= {24'h0, off_sel_r, on_sel_r};
                `REG_EXT16:  dat_o <= {16'h0, ext_r};
                `REG_STATUS: dat_o <= {26'h0, ext_ok_r, pend_r, 2'h0, obj_r, hi_r};
                `REG_MEAS:   dat_o <= {16'h0, meas_r};
                default:     dat_o <= 32'h0;
            endcase
        end
    end
endmodule // thr_switch

// ---- thr_switch_consts.vh ----
// Purpose: Constants for the delayed threshold switch
// Assumes: 25 MHz clock
// Notes:   Offsets are word byte addresses on the Wishbone slave
`ifndef THR_SWITCH_CONSTS_VH
`define THR_SWITCH_CONSTS_VH
// ****************************
// Register offsets
// ****************************
`define REG_CTRL        8'h00
`define REG_LEVEL       8'h04
`define REG_HYST        8'h08
`define REG_DELAY       8'h0C
`define REG_EXT16       8'h10
`define REG_EXT8        8'h14
`define REG_TEACH       8'h18
`define REG_STATUS      8'h1C
`define REG_MEAS        8'h20
// ****************************
// Field positions in control
// ****************************
`define CTRL_MODE_LSB   0
`define CTRL_SRC_LSB    4
`define CTRL_SOC_BIT    6
`define CTRL_DL_BIT     7
`define CTRL_CYC_LSB    8
// ****************************
// Reset values
// ****************************
`define RST_MODE        4'h0
`define RST_LEVEL       16'h4E20
`define RST_HYST        16'h0000
`define RST_DELAY_SEL   4'h8
`define RST_CYC         7'h00
// ****************************
// Timing
// ****************************
`define CLK_HZ          25000000
`define TICK_MS         100
`define TICK_CYCLES     (`CLK_HZ / 1000 * `TICK_MS)
`define CYC_UNIT_TICKS  100
// ****************************
// Encodings
// ****************************
`define SRC_FIXED       2'h0
`define SRC_WIDE        2'h1
`define SRC_NARROW      2'h2
`define SRC_TEACH       2'h3
`define ACT_NONE        2'h0
`define ACT_ON          2'h1
`define ACT_OFF         2'h2
`endif

// ---- thr_switch_checker.sv ----
// Purpose: Port-level assertions for thr_switch
// Assumes: One clock, synchronous active-high reset
// Notes:   Shadows control writes to know when sending is off
module thr_switch_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        send_o,
    input wire logic        send_val_o
);
    logic       soc_r;
    logic       cz_r;
    logic [2:0] quiet_r;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ****************************
    // Silent configuration tracker
    // ****************************
    always @(posedge clk_i) begin
        if (rst_i) begin
            soc_r <= 1'b1;
            cz_r <= 1'b1;
            quiet_r <= 3'h0;
        end else begin
            if (cyc_i && stb_i && we_i && !ack_o && adr_i == 8'h00) begin
                if (sel_i[0]) soc_r <= dat_i[6];
                if (sel_i[1]) cz_r <= (dat_i[14:8] == 7'h00);
            end
            quiet_r <= (!soc_r && cz_r) ? quiet_r + 3'(quiet_r != 3'h4) : 3'h0;
        end
    end
    // ****************************
    // Properties
    // ****************************
    ack_lat_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not acknowledged one cycle later");
    ack_one_a: assert property (ack_o |=> !ack_o)
        else $error("acknowledge longer than one cycle");
    ack_cause_a: assert property (ack_o |-> $past(cyc_i && stb_i))
        else $error("acknowledge without request");
    ack_idle_a: assert property (!(cyc_i && stb_i) |=> !ack_o)
        else $error("acknowledge after idle bus");
    rd_unmap_a: assert property (ack_o && !we_i && adr_i > 8'h20 |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    rst_bus_a: assert property ($past(rst_i) |-> !ack_o && dat_o == 32'h0)
        else $error("bus outputs not cleared by reset");
    rst_send_a: assert property ($past(rst_i) |-> !send_o && !send_val_o)
        else $error("telegram outputs not cleared by reset");
    silent_cfg_a: assert property (quiet_r == 3'h4 |-> !send_o)
        else $error("telegram sent with all sending off");
endmodule // thr_switch_checker

bind thr_switch thr_switch_checker i_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .send_o(send_o), .send_val_o(send_val_o));

// ---- telegram_sink.sv ----
// Purpose: Far-side bus model receiving switching telegrams
// Assumes: A telegram is a one-cycle send pulse with its value
// Notes:   Keeps count, last value and spacing of the last two
module telegram_sink (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic send_i,
    input wire logic val_i
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt = 0;
    int   gap = 0;
    int   now = 0;
    int   prev = 0;
    logic last = 1'b0;
    always @(posedge clk_i) begin
        now <= now + 1;
        if (!rst_i && send_i === 1'b1) begin
            cnt <= cnt + 1;
            gap <= now - prev;
            prev <= now;
            last <= val_i;
        end
    end
endmodule // telegram_sink

// ---- thr_switch_tb.sv ----
// Purpose: Self-checking bench for thr_switch
// Assumes: TICK_CYCLES of 10, so 1 s is 100 clocks
// Notes:   Telegrams are counted by telegram_sink
`include "thr_switch_consts.vh"
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
$display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module thr_switch_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, ack_o, send_o, send_val_o;
    logic [7:0] adr_i = 8'h00;
    logic [31:0] dat_i = 32'h0, dat_o, q;
    int error_cnt = 0, checks_done = 0, cycles = 0, c0;
    thr_switch #(.TICK_CYCLES(10)) i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(4'hF), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .send_o(send_o), .send_val_o(send_val_o));
    telegram_sink i_sink (.clk_i(clk_i), .rst_i(rst_i), .send_i(send_o), .val_i(send_val_o));
    initial forever #20 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 15000) begin
            error_cnt++;
            report_and_stop();
        end
    end
    // ****************************
    // Bus and telegram helpers
    // ****************************
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1;
        stb_i <= 1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 0;
        stb_i <= 0;
    endtask
    task automatic obs(input int n, input int k, input logic v);
        c0 = i_sink.cnt;
        repeat (n) @(posedge clk_i);
        `CHK(i_sink.cnt - c0, k)
        if (k > 0) `CHK(i_sink.last, v)
    endtask
    // ****************************
    // Scenarios
    // ****************************
    task automatic t_regs;
        wb(0, `REG_CTRL, 32'h0);
        `CHK(q, 32'h40)
        wb(0, `REG_LEVEL, 32'h0);
        `CHK(q, 32'h4E20)
        wb(0, `REG_DELAY, 32'h0);
        `CHK(q, 32'h88)
        wb(1, 8'h40, 32'h5A);
        wb(0, 8'h40, 32'h0);
        `CHK(q, 32'h0)
        $display("t_regs done");
    endtask
    task automatic t_modes;
        logic [3:0] md[6] = '{4'h3, 4'hB, 4'h7, 4'h8, 4'h9, 4'h0};
        int k[6] = '{1, 1, 0, 0, 0, 1};
        wb(1, `REG_DELAY, 32'h0);
        wb(1, `REG_HYST, 32'h64);
        wb(1, `REG_LEVEL, 32'h3E8);
        foreach (md[i]) begin
            wb(1, `REG_MEAS, 32'h0);
            wb(1, `REG_CTRL, {24'h0, 4'hC, md[i]});
            repeat (30) @(posedge clk_i);
            wb(1, `REG_MEAS, 32'h44D);
            obs(30, k[i], 1'b1);
        end
        wb(1, `REG_MEAS, 32'h3B6);
        obs(30, 0, 1'b0);
        wb(1, `REG_MEAS, 32'h383);
        obs(30, 1, 1'b0);
        $display("t_modes done");
    endtask
    task automatic t_delay;
        wb(1, `REG_DELAY, 32'h11);
        wb(1, `REG_MEAS, 32'h44D);
        obs(50, 0, 1'b0);
        wb(1, `REG_MEAS, 32'h383);
        obs(200, 0, 1'b0);
        wb(1, `REG_MEAS, 32'h44D);
        obs(80, 0, 1'b0);
        obs(60, 1, 1'b1);
        wb(1, `REG_MEAS, 32'h383);
        obs(80, 0, 1'b0);
        obs(60, 1, 1'b0);
        $display("t_delay done");
    endtask
    task automatic t_ext;
        wb(1, `REG_DELAY, 32'h0);
        wb(1, `REG_EXT16, 32'h1F4);
        wb(1, `REG_MEAS, 32'h3B6);
        obs(30, 0, 1'b0);
        wb(1, `REG_CTRL, 32'hD0);
        obs(30, 0, 1'b0);
        wb(1, `REG_EXT16, 32'h1F4);
        obs(30, 1, 1'b1);
        wb(1, `REG_CTRL, 32'hE0);
        wb(1, `REG_MEAS, 32'h64);
        repeat (30) @(posedge clk_i);
        wb(1, `REG_EXT8, 32'hFF);
        wb(1, `REG_MEAS, 32'h100);
        obs(30, 1, 1'b1);
        wb(1, `REG_CTRL, 32'hF0);
        wb(1, `REG_MEAS, 32'h1F3);
        repeat (30) @(posedge clk_i);
        wb(1, `REG_MEAS, 32'h258);
        wb(1, `REG_TEACH, 32'h1);
        wb(1, `REG_MEAS, 32'h259);
        obs(30, 1, 1'b1);
        $display("t_ext done");
    endtask
    task automatic t_cyc;
        wb(1, `REG_CTRL, 32'h0);
        wb(1, `REG_MEAS, 32'h44D);
        obs(40, 0, 1'b0);
        wb(1, `REG_CTRL, 32'h100);
        c0 = i_sink.cnt;
        repeat (2100) @(posedge clk_i);
        `CHK(i_sink.cnt - c0 >= 2, 1'b1)
        `CHK(i_sink.gap, 1000)
        `CHK(i_sink.last, 1'b1)
        wb(1, `REG_CTRL, 32'h104);
        wb(1, `REG_MEAS, 32'h383);
        obs(1100, 0, 1'b0);
        wb(1, `REG_CTRL, 32'h100);
        wb(1, `REG_DELAY, 32'h66);
        wb(1, `REG_MEAS, 32'h44D);
        obs(1000, 1, 1'b0);
        repeat (2100) @(posedge clk_i);
        wb(1, `REG_MEAS, 32'h383);
        obs(1000, 1, 1'b1);
        $display("t_cyc done");
    endtask
    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 0;
        t_regs();
        t_modes();
        t_delay();
        t_ext();
        t_cyc();
        report_and_stop();
    end
endmodule // thr_switch_tb
